/* bench/host_drv_model.sv */
`timescale 1ns/100ps
`default_nettype none
// Host driver: programs control and producer, reads back buffer size over APB
module host_drv_model (
  input  wire logic        i_clk_sys,
  output logic             o_psel,
  output logic             o_penable,
  output logic             o_pwrite,
  output logic [7:0]       o_paddr,
  output logic [31:0]      o_pwdata,
  input  wire logic [31:0] i_prdata,
  input  wire logic        i_pready,
  input  wire logic        i_pslverr
);
  initial begin
    o_psel = 1'b0;
    o_penable = 1'b0;
    o_pwrite = 1'b0;
    o_paddr = 8'h00;
    o_pwdata = 32'h0;
  end
  // Ring of one page; its last entry links back to the page start
  localparam int RING_PAGES = 1;
  // Buffers the filled ring holds: every entry but the link one
  function automatic int ring_buffers();
    return RING_PAGES * (rx_coalesce_pkg::ENTRIES_PER_PAGE - 1);
  endfunction
  // One transfer, held until ready is sampled high
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] r, output logic e);
    @(posedge i_clk_sys);
    o_psel <= 1'b1;
    o_pwrite <= w;
    o_paddr <= a;
    o_pwdata <= d;
    @(posedge i_clk_sys);
    o_penable <= 1'b1;
    do begin
      @(posedge i_clk_sys);
    end while (i_pready !== 1'b1);
    r = i_prdata;
    e = i_pslverr;
    o_psel <= 1'b0;
    o_penable <= 1'b0;
    // Released lines no longer show the old value
    o_paddr <= ~a;
    o_pwdata <= ~d;
  endtask
endmodule
`default_nettype wire

/* bench/rx_agg_sva.sv */
`timescale 1ns/100ps
`default_nettype none
module rx_agg_sva (
  input wire logic                         i_clk_sys,
  input wire logic                         i_reset_n,
  input wire logic                         i_psel,
  input wire logic                         i_penable,
  input wire rx_coalesce_pkg::agg_event_s  i_event,
  input wire logic                         i_event_valid,
  input wire logic [31:0]                  o_prdata,
  input wire logic                         o_pready,
  input wire logic                         o_pslverr,
  input wire rx_coalesce_pkg::completion_s o_cqe,
  input wire logic                         o_cqe_valid
);
  import rx_coalesce_pkg::*;
  logic [16:0] need;
  logic [1:0]  fl;
  // Page size taken as the reset buffer size, which the bench keeps
  assign need = (17'(o_cqe.total_bytes - o_cqe.first_frame_bytes) + 17'h00fff) >> 12;
  assign fl = o_cqe.type_error_flags[DONE_FLAG_BIT:BEGIN_FLAG_BIT];
  default clocking @(posedge i_clk_sys); endclocking
  default disable iff (!i_reset_n);
  flags_onehot_a: assert property (o_cqe_valid |-> fl inside {2'b01, 2'b10})
    else $error("bad flags");
  begin_cause_a: assert property (o_cqe_valid && fl[0] |->
    $past(i_event_valid && i_event.begin_agg, 2) && o_cqe.slot == $past(i_event.slot, 2))
    else $error("begin without event");
  page_count_a: assert property (o_cqe_valid && fl[1] |->
    o_cqe.page_count == (need > 17'd8 ? 4'd8 : need[3:0])) else $error("page count");
  page_cap_a: assert property (o_cqe_valid |-> o_cqe.page_count <= 4'd8)
    else $error("too many pages");
  cqe_pulse_a: assert property (o_cqe_valid |=> !o_cqe_valid)
    else $error("valid held");
  ready_wait_a: assert property (i_psel && i_penable && !o_pready |=> o_pready)
    else $error("no ready");
  ready_pulse_a: assert property (o_pready |=> !o_pready)
    else $error("ready held");
  err_read_a: assert property (o_pslverr |-> o_pready && o_prdata == 32'h0)
    else $error("error data");
  cover property (o_cqe_valid && fl[0]);
  cover property (o_cqe_valid && fl[1] && o_cqe.page_count != 4'd0);
  cover property (o_pslverr);
endmodule
bind rx_aggregation_completion rx_agg_sva u_sva (.i_clk_sys, .i_reset_n, .i_psel, .i_penable,
  .i_event, .i_event_valid, .o_prdata, .o_pready, .o_pslverr, .o_cqe, .o_cqe_valid);
`default_nettype wire

/* bench/tb_rx_aggregation_completion.sv */
`timescale 1ns/100ps
`default_nettype none
module tb_rx_aggregation_completion;
  import rx_coalesce_pkg::*;
  logic        clk, rst_n, psel, penable, pwrite, ev_valid, cqe_valid, hdr, pready, pslverr;
  logic        e, seen;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, r;
  logic [7:0]  pool;
  agg_event_s  ev;
  completion_s cqe, last;
  int          errors, cmp_count, ncqe, nhdr, frames;
  rx_aggregation_completion DUT (.i_clk_sys(clk), .i_reset_n(rst_n), .i_psel(psel),
    .i_penable(penable), .i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata),
    .o_prdata(prdata), .o_pready(pready), .o_pslverr(pslverr), .i_event(ev),
    .i_event_valid(ev_valid), .o_cqe(cqe), .o_cqe_valid(cqe_valid), .o_hdr_rewrite(hdr));
  host_drv_model drv (.i_clk_sys(clk), .o_psel(psel), .o_penable(penable), .o_pwrite(pwrite),
    .o_paddr(paddr), .o_pwdata(pwdata), .i_prdata(prdata), .i_pready(pready),
    .i_pslverr(pslverr));
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  always @(posedge clk) begin
    if (cqe_valid === 1'b1) begin
      ncqe++;
      last = cqe;
    end
    if (hdr === 1'b1) nhdr++;
  end
  task chk(input logic [31:0] s, input logic [31:0] x);
    cmp_count++;
    if (s !== x) begin
      errors++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, s, x);
    end
  endtask
  task wr(input logic [7:0] a, input logic [31:0] d);
    drv.xfer(1'b1, a, d, r, e);
  endtask
  task send(input logic b, input logic d, input logic [7:0] s, input logic [15:0] n);
    @(posedge clk);
    ev <= '{b, d, s, n};
    ev_valid <= 1'b1;
    @(posedge clk);
    ev_valid <= 1'b0;
  endtask
  task wait_cqe(input int n0);
    repeat (40) begin
      @(posedge clk);
      #1;
      if (ncqe != n0) break;
    end
    seen = (ncqe != n0);
  endtask
  function automatic logic [3:0] pages(input int t, input int f);
    int n = (t - f + (1 << BUF_SHIFT_RESET) - 1) >> BUF_SHIFT_RESET;
    return (n > 8) ? 4'd8 : n[3:0];
  endfunction
  task report_and_stop();
    $display("errors=%0d compares=%0d", errors, cmp_count);
    if (errors == 0 && cmp_count > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  initial begin
    #200000;
    errors++;
    report_and_stop();
  end
  initial begin
    int sl, f, t, c0, n0;
    rst_n = 1'b0;
    ev = '0;
    ev_valid = 1'b0;
    pool = 8'h00;
    void'($urandom(32'hee4d43f3));
    repeat (8) @(posedge clk);
    rst_n <= 1'b1;
    drv.xfer(1'b0, REG_BUF_SIZE, 32'h0, r, e);
    chk(r, 32'h0000000c);
    drv.xfer(1'b0, 8'h1c, 32'h0, r, e);
    chk(32'(e), 32'h1);
    wr(REG_CTRL, 32'h1);
    n0 = ncqe;
    send(1'b1, 1'b0, 8'h03, 16'h0064);
    wait_cqe(n0);
    chk(32'(seen), 32'h0);
    // Post part of the filled ring; the rest is kept back for refills
    wr(REG_PRODUCER, 32'(drv.ring_buffers() - 63));
    drv.xfer(1'b0, REG_PRODUCER, 32'h0, r, e);
    chk(r, 32'h000000c0);
    wr(REG_CTRL, 32'h3);
    for (int i = 0; i < 7; i++) begin
      sl = $urandom_range(0, 7);
      f = $urandom_range(60, 1500);
      t = (i == 0) ? f : (i == 1) ? f + 32769 : f + $urandom_range(1, 30000);
      drv.xfer(1'b0, REG_STATUS, 32'h0, r, e);
      c0 = r[15:0];
      n0 = ncqe;
      send(1'b1, 1'b0, sl[7:0], f[15:0]);
      wait_cqe(n0);
      chk(32'({seen, last.type_error_flags[5:4], last.slot}), 32'({3'b101, sl[7:0]}));
      pool[sl] = 1'b1;
      drv.xfer(1'b0, REG_ACTIVE, 32'h0, r, e);
      chk(r, 32'(pool));
      n0 = nhdr;
      send(1'b0, 1'b0, sl[7:0], 16'h0);
      repeat (4) @(posedge clk);
      chk(32'(nhdr - n0), 32'h1);
      n0 = ncqe;
      send(1'b0, 1'b1, sl[7:0], t[15:0]);
      wait_cqe(n0);
      chk(32'({seen, last.type_error_flags[5:4], last.slot}), 32'({3'b110, sl[7:0]}));
      chk(32'(last.total_bytes), 32'(t));
      chk(32'(last.first_frame_bytes), 32'(f));
      chk(32'(last.page_count), 32'(pages(t, f)));
      chk(32'(last.page_list[IDX_W-1:0]), (pages(t, f) != 4'd0) ? 32'(c0) : 32'h0);
      drv.xfer(1'b0, REG_STATUS, 32'h0, r, e);
      chk(32'(r[15:0]), 32'(c0 + pages(t, f)));
      pool[sl] = 1'b0;
      drv.xfer(1'b0, REG_ACTIVE, 32'h0, r, e);
      chk(r, 32'(pool));
      frames++;
    end
    // Producer equal to consumer: the done entry must wait for more pages
    drv.xfer(1'b0, REG_STATUS, 32'h0, r, e);
    c0 = r[15:0];
    wr(REG_PRODUCER, 32'(c0));
    n0 = ncqe;
    send(1'b1, 1'b0, 8'h05, 16'd100);
    wait_cqe(n0);
    n0 = ncqe;
    send(1'b0, 1'b1, 8'h05, 16'd8292);
    wait_cqe(n0);
    chk(32'(seen), 32'h0);
    wr(REG_PRODUCER, 32'(c0 + 4));
    wait_cqe(n0);
    chk(32'({seen, last.page_count}), 32'h12);
    report_and_stop();
  end
endmodule
`default_nettype wire

/* src/rx_aggregation_completion.sv */
`timescale 1ns/100ps
`default_nettype none

module rx_aggregation_completion #(
  parameter int SLOTS = 8
) (
  // Clock and reset
  input  wire logic                        i_clk_sys,
  input  wire logic                        i_reset_n,
  // APB slave
  input  wire logic                        i_psel,
  input  wire logic                        i_penable,
  input  wire logic                        i_pwrite,
  input  wire logic [7:0]                  i_paddr,
  input  wire logic [31:0]                 i_pwdata,
  output logic      [31:0]                 o_prdata,
  output logic                             o_pready,
  output logic                             o_pslverr,
  // Aggregation events from the receive engine
  input  wire rx_coalesce_pkg::agg_event_s i_event,
  input  wire logic                        i_event_valid,
  // Completion entries towards the completion queue writer
  output rx_coalesce_pkg::completion_s     o_cqe,
  output logic                             o_cqe_valid,
  // Header rewrite of the held first frame
  output logic                             o_hdr_rewrite
);
  import rx_coalesce_pkg::*;

  typedef enum logic [1:0] {S_IDLE, S_ALLOC, S_EMIT} state_e;

  // Register state
  logic [1:0]             ctrl_q, ctrl_d;
  logic [4:0]             buf_shift_q, buf_shift_d;
  logic [31:0]            ring_lo_q, ring_lo_d, ring_hi_q, ring_hi_d;
  logic [IDX_W-1:0]       prod_q, prod_d;
  logic [IDX_W-1:0]       cons_q, cons_d;
  logic [SLOTS-1:0]       active_q, active_d;
  logic [7:0]             starve_q, starve_d;
  logic [31:0]            prdata_q, prdata_d;
  logic                   pready_q, pready_d, pslverr_q, pslverr_d;
  // Machine state
  state_e                 state_q, state_d;
  agg_event_s             ev_q, ev_d;
  completion_s            cqe_q, cqe_d;
  logic                   cqe_valid_q, cqe_valid_d;
  logic                   rewrite_q, rewrite_d;
  logic [3:0]             need_q, need_d;
  logic [3:0]             got_q, got_d;
  // First frame length per slot, kept from begin until done
  logic [LEN_W-1:0]       first_q [SLOTS];
  logic [LEN_W-1:0]       first_d [SLOTS];

  logic                   enabled;
  logic                   apb_access;
  logic                   apb_done;
  logic [LEN_W-1:0]       rest_bytes;
  logic [LEN_W-1:0]       page_mask;
  logic [LEN_W-1:0]       pages_raw;
  logic [IDX_W-1:0]       next_cons;

  assign enabled    = ctrl_q[CTRL_AGG_EN_BIT] & ctrl_q[CTRL_RING_EN_BIT];
  assign apb_access = i_psel & i_penable & ~pready_q;
  // Writes land at the edge where the master samples ready high
  assign apb_done   = i_psel & i_penable & pready_q;
  assign page_mask  = LEN_W'((32'h1 << buf_shift_q) - 32'h1);
  assign rest_bytes = ev_q.frame_bytes - cqe_q.first_frame_bytes;
  assign pages_raw  = LEN_W'((32'(rest_bytes) + 32'(page_mask)) >> buf_shift_q);

  // Skip the link entry at the end of each ring page
  always_comb begin
    next_cons = cons_q + IDX_W'(1);
    if (next_cons[7:0] == 8'(ENTRIES_PER_PAGE - 1)) begin
      next_cons = cons_q + IDX_W'(2);
    end
  end

  // APB register file
  always_comb begin
    ctrl_d      = ctrl_q;
    buf_shift_d = buf_shift_q;
    ring_lo_d   = ring_lo_q;
    ring_hi_d   = ring_hi_q;
    prod_d      = prod_q;
    prdata_d    = APB_ZERO;
    pready_d    = apb_access;
    pslverr_d   = 1'b0;
    if (apb_access || apb_done) begin
      case (i_paddr)
        REG_CTRL: begin
          if (apb_done && i_pwrite) begin
            ctrl_d = i_pwdata[1:0];
          end
          prdata_d = {30'h0, ctrl_q};
        end
        REG_BUF_SIZE: begin
          if (apb_done && i_pwrite) begin
            buf_shift_d = i_pwdata[4:0];
          end
          prdata_d = {27'h0, buf_shift_q};
        end
        REG_RING_LO: begin
          if (apb_done && i_pwrite) begin
            ring_lo_d = i_pwdata;
          end
          prdata_d = ring_lo_q;
        end
        REG_RING_HI: begin
          if (apb_done && i_pwrite) begin
            ring_hi_d = i_pwdata;
          end
          prdata_d = ring_hi_q;
        end
        REG_PRODUCER: begin
          if (apb_done && i_pwrite) begin
            prod_d = i_pwdata[IDX_W-1:0];
          end
          prdata_d = {16'h0, prod_q};
        end
        REG_STATUS: begin
          prdata_d = {8'h0, starve_q, cons_q};
        end
        REG_ACTIVE: begin
          prdata_d = 32'(active_q);
        end
        default: begin
          pslverr_d = apb_access;
        end
      endcase
    end
  end

  // Aggregation sequencing
  always_comb begin
    state_d     = state_q;
    ev_d        = ev_q;
    cqe_d       = cqe_q;
    cqe_valid_d = 1'b0;
    rewrite_d   = 1'b0;
    need_d      = need_q;
    got_d       = got_q;
    cons_d      = cons_q;
    active_d    = active_q;
    starve_d    = starve_q;
    first_d     = first_q;
    case (state_q)
      S_IDLE: begin
        if (i_event_valid && enabled) begin
          ev_d                    = i_event;
          cqe_d                   = '0;
          cqe_d.slot              = i_event.slot;
          if (i_event.done_agg) begin
            cqe_d.type_error_flags[DONE_FLAG_BIT] = 1'b1;
            cqe_d.first_frame_bytes = first_q[i_event.slot[$clog2(SLOTS)-1:0]];
            state_d                               = S_ALLOC;
          end else if (i_event.begin_agg) begin
            cqe_d.type_error_flags[BEGIN_FLAG_BIT] = 1'b1;
            cqe_d.total_bytes                      = i_event.frame_bytes;
            cqe_d.first_frame_bytes                = i_event.frame_bytes;
            first_d[i_event.slot[$clog2(SLOTS)-1:0]] = i_event.frame_bytes;
            active_d[i_event.slot[$clog2(SLOTS)-1:0]] = 1'b1;
            state_d                                = S_EMIT;
          end else if (active_q[i_event.slot[$clog2(SLOTS)-1:0]]) begin
            rewrite_d = 1'b1;
          end
        end
      end
      S_ALLOC: begin
        // Done events arrive with the whole length; first frame length was latched
        cqe_d.total_bytes = ev_q.frame_bytes;
        if (got_q == 4'h0 && need_q == 4'h0) begin
          need_d = (pages_raw > LEN_W'(MAX_PAGES)) ? 4'(MAX_PAGES) : pages_raw[3:0];
          if (pages_raw == '0) begin
            state_d = S_EMIT;
          end
        end else if (got_q == need_q) begin
          state_d = S_EMIT;
        end else if (cons_q != prod_q) begin
          cqe_d.page_list[32'(got_q)*IDX_W +: IDX_W] = cons_q;
          cons_d = next_cons;
          got_d  = got_q + 4'h1;
          cqe_d.page_count = got_q + 4'h1;
        end else if (starve_q != 8'hff) begin
          starve_d = starve_q + 8'h1;
        end
      end
      S_EMIT: begin
        cqe_valid_d = 1'b1;
        if (cqe_q.type_error_flags[DONE_FLAG_BIT]) begin
          active_d[ev_q.slot[$clog2(SLOTS)-1:0]] = 1'b0;
        end
        need_d  = 4'h0;
        got_d   = 4'h0;
        state_d = S_IDLE;
      end
      default: begin
        state_d = S_IDLE;
      end
    endcase
    if (!enabled) begin
      cons_d = '0;
    end
  end

  always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
    if (!i_reset_n) begin
      ctrl_q      <= 2'h0;
      buf_shift_q <= BUF_SHIFT_RESET;
      ring_lo_q   <= 32'h0;
      ring_hi_q   <= 32'h0;
      prod_q      <= '0;
      cons_q      <= '0;
      active_q    <= '0;
      starve_q    <= 8'h0;
      prdata_q    <= 32'h0;
      pready_q    <= 1'b0;
      pslverr_q   <= 1'b0;
      state_q     <= S_IDLE;
      ev_q        <= '0;
      cqe_q       <= '0;
      cqe_valid_q <= 1'b0;
      rewrite_q   <= 1'b0;
      need_q      <= 4'h0;
      got_q       <= 4'h0;
      first_q     <= '{default: '0};
    end else begin
      ctrl_q      <= ctrl_d;
      buf_shift_q <= buf_shift_d;
      ring_lo_q   <= ring_lo_d;
      ring_hi_q   <= ring_hi_d;
      prod_q      <= prod_d;
      cons_q      <= cons_d;
      active_q    <= active_d;
      starve_q    <= starve_d;
      prdata_q    <= prdata_d;
      pready_q    <= pready_d;
      pslverr_q   <= pslverr_d;
      state_q     <= state_d;
      ev_q        <= ev_d;
      cqe_q       <= cqe_d;
      cqe_valid_q <= cqe_valid_d;
      rewrite_q   <= rewrite_d;
      need_q      <= need_d;
      got_q       <= got_d;
      first_q     <= first_d;
    end
  end

  assign o_prdata      = prdata_q;
  assign o_pready      = pready_q;
  assign o_pslverr     = pslverr_q;
  assign o_cqe         = cqe_q;
  assign o_cqe_valid   = cqe_valid_q;
  assign o_hdr_rewrite = rewrite_q;

endmodule

`default_nettype wire

/* src/rx_coalesce_pkg.sv */
package rx_coalesce_pkg;

  // Completion entry type and error flags byte
  localparam int TYPE_BIT       = 0;
  localparam int BEGIN_FLAG_BIT = 4;
  localparam int DONE_FLAG_BIT  = BEGIN_FLAG_BIT + 1;

  // Aggregation limits
  localparam int MAX_PAGES      = 8;
  localparam int SLOT_W         = 8;
  localparam int LEN_W          = 16;
  localparam int IDX_W          = 16;

  // Ring layout: entries per ring page, last entry links to the next page
  localparam int ENTRIES_PER_PAGE = 256;
  localparam int PAGE_SHIFT_W     = 5;

  // APB register byte addresses
  localparam logic [7:0] REG_CTRL      = 8'h00;
  localparam logic [7:0] REG_BUF_SIZE  = 8'h04;
  localparam logic [7:0] REG_RING_LO   = 8'h08;
  localparam logic [7:0] REG_RING_HI   = 8'h0c;
  localparam logic [7:0] REG_PRODUCER  = 8'h10;
  localparam logic [7:0] REG_STATUS    = 8'h14;
  localparam logic [7:0] REG_ACTIVE    = 8'h18;

  // Control field positions
  localparam int CTRL_AGG_EN_BIT  = 0;
  localparam int CTRL_RING_EN_BIT = 1;

  // Reset values
  localparam logic [4:0]  BUF_SHIFT_RESET = 5'h0c;
  localparam logic [31:0] APB_ZERO        = 32'h0;

  typedef struct packed {
    logic [7:0]                 type_error_flags;
    logic [SLOT_W-1:0]          slot;
    logic [LEN_W-1:0]           total_bytes;
    logic [LEN_W-1:0]           first_frame_bytes;
    logic [3:0]                 page_count;
    logic [MAX_PAGES*IDX_W-1:0] page_list;
  } completion_s;

  typedef struct packed {
    logic              begin_agg;
    logic              done_agg;
    logic [SLOT_W-1:0] slot;
    logic [LEN_W-1:0]  frame_bytes;
  } agg_event_s;

endpackage
